//--- logic/cpfs_pkg.sv
// Shared constants and types for the control port pin function select
`default_nettype none
package cpfs_pkg;

	// ============================================================
	// Port mode select codes
	localparam logic [1:0] CPFS_SEL_MUX = 2'h0;
	localparam logic [1:0] CPFS_SEL_NONMUX = 2'h1;
	localparam logic [1:0] CPFS_SEL_SERIAL = 2'h2;
	localparam logic [1:0] CPFS_SEL_HW = 2'h3;

	typedef enum logic [1:0] {
		CPFS_MODE_MUX,
		CPFS_MODE_NONMUX,
		CPFS_MODE_SERIAL,
		CPFS_MODE_HW
	} cpfs_mode_t;

	// ============================================================
	// Pin synchroniser and reset values
	localparam int CPFS_SYNC_W = 19;
	localparam logic [CPFS_SYNC_W-1:0] CPFS_SYNC_RST = 19'h0_0000;
	localparam logic [7:0] CPFS_BUS_RST = 8'h00;
	localparam logic [7:0] CPFS_SER_OE = 8'h01;
	localparam logic [7:0] CPFS_HOST_SER_OE = 8'h06;

	// ============================================================
	// Mode decode, used by both ends
	function automatic cpfs_mode_t cpfs_decode(input logic [1:0] sel);
		cpfs_mode_t m;
		m = CPFS_MODE_HW;
		case (sel)
			CPFS_SEL_MUX: m = CPFS_MODE_MUX;
			CPFS_SEL_NONMUX: m = CPFS_MODE_NONMUX;
			CPFS_SEL_SERIAL: m = CPFS_MODE_SERIAL;
			default: m = CPFS_MODE_HW;
		endcase
		return m;
	endfunction

endpackage
`default_nettype wire

//--- logic/cpfs_if.sv
// Pin-level carrier joining the device end and the host end
`timescale 1ns/1ps
`default_nettype none
interface cpfs_if;

	// ============================================================
	// Straps and controls driven by the host
	logic [1:0] host_port_kind_sel;
	logic hiz_and_reset_pin;
	logic tx_op_mode_sel_b1;
	logic tx_op_mode_sel_b2;
	logic [6:2] addr_pins;

	// ============================================================
	// Shared data pins, both drivers and resolved level
	logic [7:0] dev_ad_o;
	logic [7:0] dev_ad_oe;
	logic [7:0] host_ad_o;
	logic [7:0] host_ad_oe;
	logic [7:0] ad_bus;

	// ============================================================
	// Interrupt pin (open drain) shared with jitter clock strap
	logic dev_int_oe;
	logic host_jsel_o;
	logic host_jsel_oe;
	logic int_pin;

	// Resolution: device first, then host, else board pull-up
	assign ad_bus = (dev_ad_oe & dev_ad_o)
		| (~dev_ad_oe & host_ad_oe & host_ad_o)
		| (~dev_ad_oe & ~host_ad_oe);
	assign int_pin = dev_int_oe ? 1'b0
		: (host_jsel_oe ? host_jsel_o : 1'b1);

	modport dev (
		input host_port_kind_sel, hiz_and_reset_pin,
		input tx_op_mode_sel_b1, tx_op_mode_sel_b2, addr_pins,
		input ad_bus, int_pin,
		output dev_ad_o, dev_ad_oe, dev_int_oe
	);

	modport host (
		output host_port_kind_sel, hiz_and_reset_pin,
		output tx_op_mode_sel_b1, tx_op_mode_sel_b2, addr_pins,
		output host_ad_o, host_ad_oe, host_jsel_o, host_jsel_oe,
		input ad_bus, int_pin
	);

endinterface
`default_nettype wire

//--- logic/cpfs_dev.sv
// Device end: control port pin function select and pin drivers
// Operation
// - Two-bit select picks port mode
// - Interrupt pin pulled low on flagged event
// - Host drives jitter clock select in hardware mode
// - Rising hiz/reset pin resets configuration
// - Hiz/reset pin high floats all outputs
// - Hardware mode reads transmit mode pins
// - Mode 01: shared pins are data bus
// - Mode 00: shared pins carry address/data
// - Bit 7 strap disables receive termination
// - Bit 6 strap disables transmit termination
// - Bits 5,4 select receive mode
// - Bit 3 selects transmit 8k function
// - Bit 2 selects receive 8k function
// - Serial mode: bit 2 is clock
// - Serial: read on bit 0, write bit 1
// - Mux mode: host ties address pins low
// - Host sets clock polarity and phase pins
`timescale 1ns/1ps
`default_nettype none
module cpfs_dev (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Pin side
	cpfs_if.dev pins,
	// Core requests
	input wire logic int_req,
	input wire logic rd_drive,
	input wire logic [7:0] rd_data,
	input wire logic miso_bit,
	// Mode and reset status
	output logic [1:0] port_mode,
	output logic hiz_active,
	output logic cfg_reset_pulse,
	// Parallel port view
	output logic [7:0] bus_in,
	output logic [6:2] addr_in,
	// Hardware mode straps
	output logic tx_mode_b1,
	output logic tx_mode_b2,
	output logic jitter_clk_sel,
	output logic rx_term_dis,
	output logic tx_term_dis,
	output logic [1:0] rx_mode_sel,
	output logic tx_8k_sel,
	output logic rx_8k_sel,
	// Serial port view
	output logic sclk,
	output logic mosi,
	output logic cpol,
	output logic cpha
);
	import cpfs_pkg::*;

	// ============================================================
	// Pin synchronisers
	logic [CPFS_SYNC_W-1:0] raw_w;
	logic [CPFS_SYNC_W-1:0] s1_q;
	logic [CPFS_SYNC_W-1:0] s2_q;
	logic [CPFS_SYNC_W-1:0] s3_q;
	logic [CPFS_SYNC_W-1:0] flt_q;
	logic [CPFS_SYNC_W-1:0] flt_d;

	// Pack every incoming pin into one vector
	assign raw_w = {pins.int_pin, pins.tx_op_mode_sel_b2,
		pins.tx_op_mode_sel_b1, pins.hiz_and_reset_pin,
		pins.host_port_kind_sel, pins.addr_pins, pins.ad_bus};

	// Four flops per pin, three stages and a filter; a change counts once stages 2 and 3 agree
	genvar gi;
	generate
		for (gi = 0; gi < CPFS_SYNC_W; gi = gi + 1) begin : g_sync
			assign flt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi]
				: flt_q[gi];
		end
	endgenerate

	// Stage 1 feeds only stage 2
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			s1_q <= CPFS_SYNC_RST;
			s2_q <= CPFS_SYNC_RST;
			s3_q <= CPFS_SYNC_RST;
			flt_q <= CPFS_SYNC_RST;
		end else begin
			s1_q <= raw_w;
			s2_q <= s1_q;
			s3_q <= s2_q;
			flt_q <= flt_d;
		end
	end

	// ============================================================
	// Filtered pin fields
	logic [7:0] ad_f;
	logic [6:2] addr_f;
	logic [1:0] sel_f;
	logic hiz_f;
	logic b1_f;
	logic b2_f;
	logic intp_f;

	assign ad_f = flt_q[7:0];
	assign addr_f = flt_q[12:8];
	assign sel_f = flt_q[14:13];
	assign hiz_f = flt_q[15];
	assign b1_f = flt_q[16];
	assign b2_f = flt_q[17];
	assign intp_f = flt_q[18];

	// ============================================================
	// Mode decode
	cpfs_mode_t mode_w;
	logic is_par_w;
	logic is_ser_w;
	logic is_hw_w;

	assign mode_w = cpfs_decode(sel_f);
	assign is_par_w = (mode_w == CPFS_MODE_MUX)
		|| (mode_w == CPFS_MODE_NONMUX);
	assign is_ser_w = (mode_w == CPFS_MODE_SERIAL);
	assign is_hw_w = (mode_w == CPFS_MODE_HW);

	// ============================================================
	// Pin drive decisions
	logic [7:0] ad_oe_d;
	logic [7:0] ad_o_d;
	logic int_oe_d;

	// Hiz overrides every driver, so a board test sees no contention
	assign ad_oe_d = hiz_f ? CPFS_BUS_RST
		: is_par_w ? {8{rd_drive}}
		: is_ser_w ? CPFS_SER_OE
		: CPFS_BUS_RST;
	assign ad_o_d = is_ser_w ? {7'h00, miso_bit} : rd_data;
	// In hardware mode the pin is a strap input, so it stays released
	assign int_oe_d = int_req && !hiz_f && !is_hw_w;

	logic [7:0] ad_oe_q;
	logic [7:0] ad_o_q;
	logic int_oe_q;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ad_oe_q <= CPFS_BUS_RST;
			ad_o_q <= CPFS_BUS_RST;
			int_oe_q <= 1'b0;
		end else begin
			ad_oe_q <= ad_oe_d;
			ad_o_q <= ad_o_d;
			int_oe_q <= int_oe_d;
		end
	end

	assign pins.dev_ad_oe = ad_oe_q;
	assign pins.dev_ad_o = ad_o_q;
	assign pins.dev_int_oe = int_oe_q;

	// ============================================================
	// Mode, hiz and configuration reset
	logic hiz_prev_q;
	logic cfg_rst_d;

	// Only the low-to-high edge resets; a held level only floats pins
	assign cfg_rst_d = hiz_f && !hiz_prev_q;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			hiz_prev_q <= 1'b0;
			cfg_reset_pulse <= 1'b0;
			hiz_active <= 1'b0;
			port_mode <= CPFS_SEL_MUX;
		end else begin
			hiz_prev_q <= hiz_f;
			cfg_reset_pulse <= cfg_rst_d;
			hiz_active <= hiz_f;
			port_mode <= sel_f;
		end
	end

	// ============================================================
	// Parallel port view
	logic [6:2] addr_d;

	// Separate address pins carry nothing in mux mode
	assign addr_d = (mode_w == CPFS_MODE_NONMUX) ? addr_f
		: 5'h00;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			bus_in <= CPFS_BUS_RST;
			addr_in <= 5'h00;
		end else begin
			bus_in <= is_par_w ? ad_f : CPFS_BUS_RST;
			addr_in <= addr_d;
		end
	end

	// ============================================================
	// Hardware mode straps, held when another mode is selected
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			tx_mode_b1 <= 1'b0;
			tx_mode_b2 <= 1'b0;
			jitter_clk_sel <= 1'b0;
			rx_term_dis <= 1'b0;
			tx_term_dis <= 1'b0;
			rx_mode_sel <= 2'h0;
			tx_8k_sel <= 1'b0;
			rx_8k_sel <= 1'b0;
		end else if (is_hw_w) begin
			tx_mode_b1 <= b1_f;
			tx_mode_b2 <= b2_f;
			jitter_clk_sel <= intp_f;
			rx_term_dis <= ad_f[7];
			tx_term_dis <= ad_f[6];
			rx_mode_sel <= ad_f[5:4];
			tx_8k_sel <= ad_f[3];
			rx_8k_sel <= ad_f[2];
		end
	end

	// ============================================================
	// Serial port view; zero outside serial mode
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			sclk <= 1'b0;
			mosi <= 1'b0;
			cpol <= 1'b0;
			cpha <= 1'b0;
		end else begin
			sclk <= is_ser_w && ad_f[2];
			mosi <= is_ser_w && ad_f[1];
			cpol <= is_ser_w && addr_f[5];
			cpha <= is_ser_w && addr_f[4];
		end
	end

endmodule
`default_nettype wire

//--- logic/cpfs_host.sv
// Host end: drives straps, parallel data and serial pins of the device
`timescale 1ns/1ps
`default_nettype none
module cpfs_host (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Pin side
	cpfs_if.host pins,
	// Mode and test controls
	input wire logic [1:0] mode_sel,
	input wire logic hiz_req,
	// Parallel write side
	input wire logic wr_drive,
	input wire logic [7:0] wr_data,
	input wire logic [6:2] addr_val,
	// Hardware mode straps
	input wire logic [7:0] hw_straps,
	input wire logic tx_b1,
	input wire logic tx_b2,
	input wire logic jsel_high,
	// Serial controls
	input wire logic sclk_in,
	input wire logic mosi_in,
	input wire logic cpol_in,
	input wire logic cpha_in,
	// Observed device pins
	output logic [7:0] bus_rd,
	output logic int_active
);
	import cpfs_pkg::*;

	// ============================================================
	// Drive decisions per mode
	cpfs_mode_t mode_w;
	logic [7:0] ad_oe_d;
	logic [7:0] ad_o_d;
	logic [6:2] addr_d;

	assign mode_w = cpfs_decode(mode_sel);
	// Serial mode releases bit 0 so the device alone drives read data
	assign ad_oe_d = (mode_w == CPFS_MODE_SERIAL) ? CPFS_HOST_SER_OE
		: (mode_w == CPFS_MODE_HW) ? 8'hFF
		: {8{wr_drive}};
	assign ad_o_d = (mode_w == CPFS_MODE_SERIAL)
		? {5'h00, sclk_in, mosi_in, 1'b0}
		: (mode_w == CPFS_MODE_HW) ? hw_straps : wr_data;
	assign addr_d = (mode_w == CPFS_MODE_MUX) ? 5'h00
		: (mode_w == CPFS_MODE_SERIAL)
		? {addr_val[6], cpol_in, cpha_in, addr_val[3:2]}
		: addr_val;

	// ============================================================
	// Pin flops
	logic [7:0] ad_oe_q;
	logic [7:0] ad_o_q;
	logic [6:2] addr_q;
	logic [1:0] sel_q;
	logic hiz_q;
	logic b1_q;
	logic b2_q;
	logic jsel_oe_q;
	logic jsel_o_q;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ad_oe_q <= CPFS_BUS_RST;
			ad_o_q <= CPFS_BUS_RST;
			addr_q <= 5'h00;
			sel_q <= CPFS_SEL_MUX;
			hiz_q <= 1'b0;
			b1_q <= 1'b0;
			b2_q <= 1'b0;
			jsel_oe_q <= 1'b0;
			jsel_o_q <= 1'b0;
		end else begin
			ad_oe_q <= ad_oe_d;
			ad_o_q <= ad_o_d;
			addr_q <= addr_d;
			sel_q <= mode_sel;
			hiz_q <= hiz_req;
			b1_q <= tx_b1;
			b2_q <= tx_b2;
			jsel_oe_q <= (mode_w == CPFS_MODE_HW);
			jsel_o_q <= jsel_high;
		end
	end

	assign pins.host_ad_oe = ad_oe_q;
	assign pins.host_ad_o = ad_o_q;
	assign pins.addr_pins = addr_q;
	assign pins.host_port_kind_sel = sel_q;
	assign pins.hiz_and_reset_pin = hiz_q;
	assign pins.tx_op_mode_sel_b1 = b1_q;
	assign pins.tx_op_mode_sel_b2 = b2_q;
	assign pins.host_jsel_oe = jsel_oe_q;
	assign pins.host_jsel_o = jsel_o_q;

	// ============================================================
	// Observed pins; device logic shares this clock, so no syncing
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			bus_rd <= CPFS_BUS_RST;
			int_active <= 1'b0;
		end else begin
			bus_rd <= pins.ad_bus;
			int_active <= !pins.int_pin && !jsel_oe_q;
		end
	end

endmodule
`default_nettype wire

//--- tb/cpfs_properties.sv
// Checker for the pin carrier between the device and host ends
`timescale 1ns/1ps
`default_nettype none
module cpfs_properties (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Carrier signals
	input wire logic [1:0] host_port_kind_sel,
	input wire logic hiz_and_reset_pin,
	input wire logic [7:0] dev_ad_o,
	input wire logic [7:0] dev_ad_oe,
	input wire logic [7:0] host_ad_oe,
	input wire logic dev_int_oe,
	input wire logic [7:0] ad_bus,
	input wire logic int_pin
);
	import cpfs_pkg::*;

	// ============================================================
	// Held pin levels; seven edges covers sync plus filter
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	sequence hiz_held;
		hiz_and_reset_pin [*7];
	endsequence
	sequence hw_held;
		(host_port_kind_sel == CPFS_SEL_HW) [*7];
	endsequence
	sequence ser_held;
		(host_port_kind_sel == CPFS_SEL_SERIAL && !hiz_and_reset_pin) [*7];
	endsequence
	sequence par_held;
		(!host_port_kind_sel[1] && !hiz_and_reset_pin) [*7];
	endsequence

	// ============================================================
	// Properties
	a_hiz_bus_free: assert property (hiz_held |-> dev_ad_oe == 8'h00)
		else $error("bus driven while floated");
	a_hiz_int_free: assert property (hiz_held |-> !dev_int_oe)
		else $error("interrupt pulled while floated");
	a_hw_bus_free: assert property (hw_held |-> dev_ad_oe == 8'h00)
		else $error("strap pins driven in hardware mode");
	a_hw_int_free: assert property (hw_held |-> !dev_int_oe)
		else $error("clock select strap pulled");
	a_serial_miso_only: assert property (ser_held
		|-> dev_ad_oe == CPFS_SER_OE)
		else $error("serial mode drive mask wrong");
	a_par_whole_byte: assert property (par_held
		|-> dev_ad_oe == 8'h00 || dev_ad_oe == 8'hFF)
		else $error("parallel byte partly driven");
	a_drive_wins: assert property (
		(dev_ad_oe & (ad_bus ^ dev_ad_o)) == 8'h00)
		else $error("bus level differs from device drive");
	// Both ends on one bit at once would fight on the board
	a_no_bus_fight: assert property (~|(dev_ad_oe & host_ad_oe))
		else $error("device and host drive the same bit");
	a_int_pulls_low: assert property (dev_int_oe |-> !int_pin)
		else $error("interrupt pin not low");
endmodule
`default_nettype wire

//--- tb/control_port_pin_function_select_tb.sv
// Testbench joining device end and host end over the carrier
`timescale 1ns/1ps
`default_nettype none
module control_port_pin_function_select_tb;
	import cpfs_pkg::*;

	// ============================================================
	// Stimulus and observed signals
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic int_req = 1'b0, rd_drive = 1'b0, miso_bit = 1'b0;
	logic [7:0] rd_data = 8'h00, wr_data = 8'h00, hw_straps = 8'h00;
	logic [1:0] mode_sel = 2'h0;
	logic hiz_req = 1'b0, wr_drive = 1'b0, tx_b1 = 1'b0, tx_b2 = 1'b0;
	logic jsel_high = 1'b0, sclk_in = 1'b0, mosi_in = 1'b0;
	logic cpol_in = 1'b0, cpha_in = 1'b0;
	logic [6:2] addr_val = 5'h00;
	logic [1:0] port_mode, rx_mode_sel;
	logic hiz_active, cfg_reset_pulse, tx_mode_b1, tx_mode_b2;
	logic jitter_clk_sel, rx_term_dis, tx_term_dis, tx_8k_sel, rx_8k_sel;
	logic sclk, mosi, cpol, cpha, int_active;
	logic [7:0] bus_in, bus_rd;
	logic [6:2] addr_in;
	int bad_count = 0;
	int cmp_count = 0;

	// Clock at 40 MHz
	always #12.5 clk_sys = ~clk_sys;

	// ============================================================
	// Both ends on one carrier, checker beside it
	cpfs_if bus();
	cpfs_dev cpfs_dev_inst (.clk_sys, .nrst, .pins(bus), .int_req,
		.rd_drive, .rd_data, .miso_bit, .port_mode, .hiz_active,
		.cfg_reset_pulse, .bus_in, .addr_in, .tx_mode_b1, .tx_mode_b2,
		.jitter_clk_sel, .rx_term_dis, .tx_term_dis, .rx_mode_sel,
		.tx_8k_sel, .rx_8k_sel, .sclk, .mosi, .cpol, .cpha);
	cpfs_host cpfs_host_inst (.clk_sys, .nrst, .pins(bus), .mode_sel,
		.hiz_req, .wr_drive, .wr_data, .addr_val, .hw_straps, .tx_b1,
		.tx_b2, .jsel_high, .sclk_in, .mosi_in, .cpol_in, .cpha_in,
		.bus_rd, .int_active);
	cpfs_properties cpfs_properties_inst (.clk_sys, .nrst,
		.host_port_kind_sel(bus.host_port_kind_sel),
		.hiz_and_reset_pin(bus.hiz_and_reset_pin),
		.dev_ad_o(bus.dev_ad_o), .dev_ad_oe(bus.dev_ad_oe),
		.host_ad_oe(bus.host_ad_oe),
		.dev_int_oe(bus.dev_int_oe), .ad_bus(bus.ad_bus),
		.int_pin(bus.int_pin));

	// ============================================================
	// Shared helpers
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h",
				$time, got, exp);
		end
	endtask

	// Host flop, five device edges, host read back
	task automatic settle();
		repeat (8) @(negedge clk_sys);
	endtask

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ============================================================
	// Scenarios
	task automatic t_par();
		for (int m = 0; m < 2; m++) begin
			mode_sel = m[1:0];
			wr_data = 8'h5A;
			addr_val = 5'h13;
			wr_drive = 1'b1;
			settle();
			chk({6'h00, port_mode}, m[7:0]);
			chk(bus_in, 8'h5A);
			chk({3'h0, addr_in}, (m == 1) ? 8'h13 : 8'h00);
			wr_drive = 1'b0;
			rd_drive = 1'b1;
			rd_data = 8'hC3;
			settle();
			chk(bus_rd, 8'hC3);
			rd_drive = 1'b0;
		end
		$display("parallel test done");
	endtask

	task automatic t_hw(input logic [7:0] s, input logic b);
		mode_sel = CPFS_SEL_HW;
		hw_straps = s;
		tx_b1 = b;
		tx_b2 = !b;
		jsel_high = b;
		settle();
		chk({6'h00, port_mode}, 8'h03);
		chk({rx_term_dis, tx_term_dis, rx_mode_sel, tx_8k_sel, rx_8k_sel,
			2'h0}, s & 8'hFC);
		chk({6'h00, tx_mode_b2, tx_mode_b1}, {6'h00, !b, b});
		chk({7'h00, jitter_clk_sel}, {7'h00, b});
		// Request raised only once settled; the pin is a strap here
		int_req = 1'b1;
		settle();
		chk({7'h00, bus.int_pin}, {7'h00, b});
		chk({7'h00, jitter_clk_sel}, {7'h00, b});
		int_req = 1'b0;
		$display("hardware test done");
	endtask

	task automatic t_ser(input logic b);
		mode_sel = CPFS_SEL_SERIAL;
		{sclk_in, mosi_in, cpol_in, cpha_in, miso_bit} = {b, !b, b, !b, !b};
		settle();
		chk({4'h0, sclk, mosi, cpol, cpha},
			{4'h0, b, !b, b, !b});
		chk({7'h00, bus_rd[0]}, {7'h00, !b});
		chk(bus_in, 8'h00);
		// Straps from the last hardware pass must still be held
		chk({rx_term_dis, tx_term_dis, rx_mode_sel, tx_8k_sel, rx_8k_sel,
			tx_mode_b2, tx_mode_b1}, 8'h56);
		$display("serial test done");
	endtask

	task automatic t_int_hiz();
		int n;
		mode_sel = CPFS_SEL_NONMUX;
		int_req = 1'b1;
		rd_drive = 1'b1;
		rd_data = 8'h0F;
		settle();
		chk({7'h00, int_active}, 8'h01);
		n = 0;
		hiz_req = 1'b1;
		repeat (10) begin
			@(negedge clk_sys);
			n += cfg_reset_pulse;
		end
		chk(n[7:0], 8'h01);
		chk({7'h00, hiz_active}, 8'h01);
		chk(bus_rd, 8'hFF);
		chk({7'h00, int_active}, 8'h00);
		{hiz_req, int_req, rd_drive} = 3'h0;
		settle();
		chk({7'h00, hiz_active}, 8'h00);
		$display("interrupt and float test done");
	endtask

	// ============================================================
	// Main sequence
	initial begin
		repeat (16) @(negedge clk_sys);
		nrst = 1'b1;
		t_par();
		t_hw(8'hA8, 1'b1);
		t_hw(8'h54, 1'b0);
		t_ser(1'b1);
		t_ser(1'b0);
		t_int_hiz();
		give_verdict();
	end
endmodule
`default_nettype wire
